// [hbp_pkg.sv]
// Constants, register map and types for the boot host port controller
package hbp_pkg;

    // ========================================
    // Clock and strobe timing
    localparam int CLK_MHZ     = 50;
    localparam int STROBE_NS   = 80;
    localparam int RECOVER_NS  = 40;
    localparam int STROBE_CYC  = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;

    // ========================================
    // Device pins and device map
    localparam int DEV_ADDR_W = 13;
    localparam int DEV_DATA_W = 8;
    localparam int SYS_ADDR_W = 20;
    localparam logic [12:0] PRESENCE_OFS   = 13'h1046;
    localparam logic [7:0]  PRESENCE_RST   = 8'h82;
    localparam int          TOGGLE_BIT     = 2;
    localparam logic [7:0]  TOGGLE_MASK    = 8'h04;
    localparam logic [12:0] BOOT_MODE_OFS  = 13'h1070;
    localparam logic [7:0]  ASYNC_BOOT_VAL = 8'h8F;
    localparam int          BURST_LEN      = 4;

    // ========================================
    // Host memory map
    localparam logic [19:0] TOP_BASE = 20'hF_E000;
    localparam logic [19:0] EXP_LO   = 20'hC_8000;
    localparam logic [19:0] EXP_HI   = 20'hE_FFFF;
    localparam logic [19:0] WIN_RST  = 20'hD_0000;

    // ========================================
    // Controller registers on AHB-Lite
    localparam logic [7:0] REG_CMD     = 8'h00;
    localparam logic [7:0] REG_SYSADDR = 8'h04;
    localparam logic [7:0] REG_WDATA   = 8'h08;
    localparam logic [7:0] REG_WINBASE = 8'h0C;
    localparam logic [7:0] REG_MODE    = 8'h10;
    localparam logic [7:0] REG_RDATA   = 8'h14;
    localparam logic [7:0] REG_STATUS  = 8'h18;
    localparam logic       MODE_RST    = 1'b1;

    typedef enum logic [2:0] {
        OP_NONE, OP_READ, OP_WRITE, OP_PROBE, OP_BOOT, OP_BURST
    } hbp_op_type;

endpackage

// [hbp_strobe_seq.sv]
// One SRAM-like strobe cycle on the device pins, optionally held for bursts
module hbp_strobe_seq import hbp_pkg::*; (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    // Request side
    input  wire logic                  req,
    input  wire logic                  wr,
    input  wire logic                  hold,
    input  wire logic [DEV_ADDR_W-1:0] addr,
    input  wire logic [DEV_DATA_W-1:0] wdata,
    output logic                       ready,
    output logic                       ack,
    output logic [DEV_DATA_W-1:0]      rdata,
    // Device pins
    output logic [DEV_ADDR_W-1:0]      dev_addr,
    output logic [DEV_DATA_W-1:0]      dev_data_out,
    output logic                       dev_data_oe_n,
    input  wire logic [DEV_DATA_W-1:0] dev_data_in,
    output logic                       dev_ce_n,
    output logic                       dev_oe_n,
    output logic                       dev_we_n
);

    typedef enum logic [2:0] {
        S_IDLE, S_SETUP, S_STROBE, S_HELD, S_RECOV
    } hbp_seq_type;

    hbp_seq_type           state_q, state_d;
    logic [3:0]            cnt_q, cnt_d;
    logic                  wr_q, wr_d, hold_q, hold_d, ack_q, ack_d;
    logic [DEV_ADDR_W-1:0] addr_q, addr_d;
    logic [DEV_DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
    logic                  ce_q, ce_d, oe_q, oe_d, we_q, we_d, doe_q, doe_d;

    // ========================================
    // Strobe sequencing
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        wr_d    = wr_q;
        hold_d  = hold_q;
        addr_d  = addr_q;
        wd_d    = wd_q;
        rd_d    = rd_q;
        ack_d   = 1'b0;
        ce_d    = ce_q;
        oe_d    = oe_q;
        we_d    = we_q;
        doe_d   = doe_q;
        case (state_q)
            S_IDLE: begin
                if (req) begin
                    addr_d  = addr;
                    wd_d    = wdata;
                    wr_d    = wr;
                    hold_d  = hold & ~wr;
                    ce_d    = 1'b0;
                    doe_d   = ~wr;
                    state_d = S_SETUP;
                end
            end
            S_SETUP: begin
                oe_d    = wr_q;
                we_d    = ~wr_q;
                cnt_d   = 4'(STROBE_CYC - 1);
                state_d = S_STROBE;
            end
            S_STROBE: begin
                if (cnt_q != 4'd0) begin
                    cnt_d = cnt_q - 4'd1;
                end else begin
                    ack_d = 1'b1;
                    rd_d  = dev_data_in;
                    if (hold_q) begin
                        state_d = S_HELD;              // [RULE6]
                    end else begin
                        ce_d    = 1'b1;
                        oe_d    = 1'b1;
                        we_d    = 1'b1;
                        cnt_d   = 4'(RECOVER_CYC - 1);
                        state_d = S_RECOV;             // [RULE4]
                    end
                end
            end
            S_HELD: begin
                if (req) begin
                    addr_d  = addr;                    // [RULE6]
                    hold_d  = hold;
                    cnt_d   = 4'(STROBE_CYC - 1);
                    state_d = S_STROBE;
                end
            end
            S_RECOV: begin
                doe_d = 1'b1;
                if (cnt_q != 4'd0) begin
                    cnt_d = cnt_q - 4'd1;
                end else begin
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q <= S_IDLE;
            cnt_q   <= 4'd0;
            wr_q    <= 1'b0;
            hold_q  <= 1'b0;
            ack_q   <= 1'b0;
            addr_q  <= '0;
            wd_q    <= '0;
            rd_q    <= '0;
            ce_q    <= 1'b1;
            oe_q    <= 1'b1;
            we_q    <= 1'b1;
            doe_q   <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            wr_q    <= wr_d;
            hold_q  <= hold_d;
            ack_q   <= ack_d;
            addr_q  <= addr_d;
            wd_q    <= wd_d;
            rd_q    <= rd_d;
            ce_q    <= ce_d;
            oe_q    <= oe_d;
            we_q    <= we_d;
            doe_q   <= doe_d;
        end
    end

    assign ready         = (state_q == S_IDLE) || (state_q == S_HELD);
    assign ack           = ack_q;
    assign rdata         = rd_q;
    assign dev_addr      = addr_q;
    assign dev_data_out  = wd_q;
    assign dev_data_oe_n = doe_q;
    assign dev_ce_n      = ce_q;
    assign dev_oe_n      = oe_q;
    assign dev_we_n      = we_q;

    // ========================================
    // Checks
    property p_strobe_excl;
        @(posedge clock) disable iff (!reset_n)
        !(dev_oe_n == 1'b0 && dev_we_n == 1'b0);
    endproperty
    a_strobe_excl: assert property (p_strobe_excl) // [RULE9]
        else $error("read and write strobes together");

    property p_strobe_len;
        @(posedge clock) disable iff (!reset_n)
        $fell(dev_we_n) |-> (!dev_we_n && !dev_ce_n) [*4] ##1 dev_we_n;
    endproperty
    a_strobe_len: assert property (p_strobe_len) // [RULE9]
        else $error("write strobe width wrong");

    property p_drive_write;
        @(posedge clock) disable iff (!reset_n)
        !dev_data_oe_n |-> dev_oe_n;
    endproperty
    a_drive_write: assert property (p_drive_write) // [RULE9]
        else $error("data driven during read");

    c_held: cover property (@(posedge clock) disable iff (!reset_n)
        state_q == S_HELD ##[1:20] state_q == S_STROBE);

endmodule

// [hbp_host.sv]
// Host controller for the boot host port, programmed over AHB-Lite
// Overview of operation
// [RULE1] Probe reads the presence register twice and expects bit 2 toggled.
// [RULE2] Presence register sits at device offset 1046 hex, read only.
// [RULE3] Presence reserved bits must match 82H outside the toggle bit.
// [RULE4] Without async boot mode, every burst beat is a separate strobe cycle.
// [RULE5] Boot command writes 8FH to the boot access mode byte.
// [RULE6] Async boot mode bursts hold select and read low, stepping address.
// [RULE7] Device returns to strobe-edge clocking after boot reads finish; the model never leaves async mode and the host clears async_q only on reset.
// [RULE8] Wide fetches use async boot mode when booting from the device.
// [RULE9] Pins: 13 address lines, 8 data lines, select, read, write strobes.
// [RULE10] Select asserts only for accesses inside one 8KB window; probe and boot commands assert select without checking the window.
// [RULE11] Device anti-aliases windows larger than 8KB; the model decodes only its 13 address lines and has no anti-aliasing.
// [RULE12] After power-up the CPU fetches first code from the boot block.
// [RULE13] After reset map to top segment, then software remaps to expansion.
// [RULE14] Expansion window base must lie within 0C8000H to 0EFFFFH.
// [RULE15] Device registers transactions on edges of the three strobes.
// [RULE16] Only presence register reads advance the toggle bit.
//
// Chosen here: register access over AHB-Lite.
module hbp_host import hbp_pkg::*; (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // Device pins
    output logic [DEV_ADDR_W-1:0]      dev_addr,
    output logic [DEV_DATA_W-1:0]      dev_data_out,
    output logic                       dev_data_oe_n,
    input  wire logic [DEV_DATA_W-1:0] dev_data_in,
    output logic                       dev_ce_n,
    output logic                       dev_oe_n,
    output logic                       dev_we_n
);

    typedef enum logic [1:0] {M_IDLE, M_ISSUE, M_WAIT} hbp_main_type;

    hbp_main_type          st_q, st_d;
    hbp_op_type            op_q, op_d;
    logic [1:0]            beat_q, beat_d;
    logic [SYS_ADDR_W-1:0] sys_q, sys_d, win_q, win_d;
    logic [7:0]            wdat_q, wdat_d;
    logic [31:0]           rdat_q, rdat_d, hrd_q, hrd_d;
    logic                  map_q, map_d, async_q, async_d;
    logic                  pres_q, pres_d, err_q, err_d;
    logic                  pend_q, pend_d, hrdy_q;
    logic [7:0]            wa_q, wa_d;
    logic                  req, wr, hold, rdy, ack;
    logic [DEV_ADDR_W-1:0] addr;
    logic [DEV_DATA_W-1:0] wd, rd;
    logic [SYS_ADDR_W-1:0] base;
    logic                  in_win, last, cmd_wr, sta_wr;
    hbp_op_type            new_op;

    // ========================================
    // Window decode
    assign base   = map_q ? TOP_BASE : win_q;             // [RULE13]
    assign in_win = sys_q[19:13] == base[19:13];          // [RULE10]
    assign last   = beat_q == 2'(BURST_LEN - 1);
    assign new_op = hbp_op_type'(hwdata[2:0]);
    assign cmd_wr = pend_q && wa_q == REG_CMD;
    assign sta_wr = pend_q && wa_q == REG_STATUS;

    // ========================================
    // Bus slave and register file
    always_comb begin
        pend_d = hsel && hready && htrans[1] && hwrite;
        wa_d   = {haddr[7:2], 2'b00};
        hrd_d  = hrd_q;
        sys_d  = sys_q;
        wdat_d = wdat_q;
        win_d  = win_q;
        map_d  = map_q;
        if (hsel && hready && htrans[1] && !hwrite) begin
            case ({haddr[7:2], 2'b00})
                REG_SYSADDR: hrd_d = 32'(sys_q);
                REG_WDATA:   hrd_d = 32'(wdat_q);
                REG_WINBASE: hrd_d = 32'(win_q);
                REG_MODE:    hrd_d = {30'h0, async_q, map_q};
                REG_RDATA:   hrd_d = rdat_q;
                REG_STATUS:  hrd_d = {29'h0, err_q, pres_q, st_q != M_IDLE};
                default:     hrd_d = 32'h0000_0000;
            endcase
        end
        if (pend_q) begin
            case (wa_q)
                REG_SYSADDR: sys_d  = hwdata[SYS_ADDR_W-1:0];
                REG_WDATA:   wdat_d = hwdata[7:0];
                REG_MODE:    map_d  = hwdata[0];          // [RULE13]
                REG_WINBASE: begin
                    if (hwdata[19:0] >= EXP_LO && hwdata[19:0] <= EXP_HI
                        && hwdata[12:0] == 13'h0000) begin
                        win_d = hwdata[19:0];             // [RULE14]
                    end
                end
                default: ;
            endcase
        end
    end

    // ========================================
    // Command sequencing
    always_comb begin
        st_d    = st_q;
        op_d    = op_q;
        beat_d  = beat_q;
        rdat_d  = rdat_q;
        async_d = async_q;
        pres_d  = pres_q;
        err_d   = err_q;
        req     = 1'b0;
        wr      = 1'b0;
        hold    = 1'b0;
        addr    = sys_q[12:0];
        wd      = wdat_q;
        if (sta_wr && hwdata[2]) begin
            err_d = 1'b0;
        end
        case (st_q)
            M_IDLE: begin
                if (cmd_wr && new_op != OP_NONE) begin
                    if ((new_op == OP_READ || new_op == OP_WRITE
                        || new_op == OP_BURST) && !in_win) begin
                        err_d = 1'b1;                     // [RULE10]
                    end else begin
                        op_d   = new_op;
                        beat_d = 2'd0;
                        rdat_d = 32'h0000_0000;
                        if (new_op == OP_PROBE) begin
                            pres_d = 1'b0;
                        end
                        st_d = M_ISSUE;
                    end
                end
            end
            M_ISSUE: begin
                case (op_q)
                    OP_WRITE: wr = 1'b1;
                    OP_PROBE: addr = PRESENCE_OFS;        // [RULE1] [RULE2]
                    OP_BOOT: begin
                        wr   = 1'b1;
                        addr = BOOT_MODE_OFS;             // [RULE5]
                        wd   = ASYNC_BOOT_VAL;
                    end
                    OP_BURST: begin
                        addr = sys_q[12:0] + 13'(beat_q);
                        hold = async_q && !last;          // [RULE8] [RULE4]
                    end
                    default: ;
                endcase
                req = rdy;
                if (rdy) begin
                    st_d = M_WAIT;
                end
            end
            M_WAIT: begin
                if (ack) begin
                    rdat_d[8*beat_q +: 8] = rd;
                    if (op_q == OP_BOOT) begin
                        async_d = 1'b1;
                    end
                    if (op_q == OP_PROBE && beat_q == 2'd1) begin
                        pres_d = (rd[TOGGLE_BIT] != rdat_q[TOGGLE_BIT])
                            && ((rd & ~TOGGLE_MASK)
                                == (PRESENCE_RST & ~TOGGLE_MASK)); // [RULE3]
                    end
                    if ((op_q == OP_PROBE && beat_q == 2'd0)
                        || (op_q == OP_BURST && !last)) begin
                        beat_d = beat_q + 2'd1;
                        st_d   = M_ISSUE;
                    end else begin
                        st_d = M_IDLE;
                    end
                end
            end
            default: st_d = M_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_q    <= M_IDLE;
            op_q    <= OP_NONE;
            beat_q  <= 2'd0;
            sys_q   <= '0;
            wdat_q  <= 8'h00;
            win_q   <= WIN_RST;
            rdat_q  <= 32'h0000_0000;
            hrd_q   <= 32'h0000_0000;
            map_q   <= MODE_RST;                          // [RULE12]
            async_q <= 1'b0;
            pres_q  <= 1'b0;
            err_q   <= 1'b0;
            pend_q  <= 1'b0;
            wa_q    <= 8'h00;
            hrdy_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            op_q    <= op_d;
            beat_q  <= beat_d;
            sys_q   <= sys_d;
            wdat_q  <= wdat_d;
            win_q   <= win_d;
            rdat_q  <= rdat_d;
            hrd_q   <= hrd_d;
            map_q   <= map_d;
            async_q <= async_d;
            pres_q  <= pres_d;
            err_q   <= err_d;
            pend_q  <= pend_d;
            wa_q    <= wa_d;
            hrdy_q  <= 1'b1;
        end
    end

    assign hreadyout = hrdy_q;
    assign hresp     = 1'b0;
    assign hrdata    = hrd_q;

    hbp_strobe_seq u_seq (
        .clock         (clock),
        .reset_n       (reset_n),
        .req           (req),
        .wr            (wr),
        .hold          (hold),
        .addr          (addr),
        .wdata         (wd),
        .ready         (rdy),
        .ack           (ack),
        .rdata         (rd),
        .dev_addr      (dev_addr),
        .dev_data_out  (dev_data_out),
        .dev_data_oe_n (dev_data_oe_n),
        .dev_data_in   (dev_data_in),
        .dev_ce_n      (dev_ce_n),
        .dev_oe_n      (dev_oe_n),
        .dev_we_n      (dev_we_n)
    );

    // ========================================
    // Checks
    property p_boot_code;
        @(posedge clock) disable iff (!reset_n)
        req && op_q == OP_BOOT |-> ##2 dev_addr == BOOT_MODE_OFS
            && dev_data_out == ASYNC_BOOT_VAL && !dev_data_oe_n;
    endproperty
    a_boot_code: assert property (p_boot_code) // [RULE5]
        else $error("boot mode write wrong");

    property p_probe_addr;
        @(posedge clock) disable iff (!reset_n)
        req && op_q == OP_PROBE |-> !wr ##2 dev_addr == PRESENCE_OFS;
    endproperty
    a_probe_addr: assert property (p_probe_addr) // [RULE1]
        else $error("probe address wrong");

    property p_present;
        @(posedge clock) disable iff (!reset_n)
        $rose(pres_q) |-> rdat_q[TOGGLE_BIT] != rdat_q[8 + TOGGLE_BIT];
    endproperty
    a_present: assert property (p_present) // [RULE1]
        else $error("presence without toggle");

    property p_held_burst;
        @(posedge clock) disable iff (!reset_n)
        ack && op_q == OP_BURST && async_q && !last
            |-> ##1 !dev_ce_n && !dev_oe_n;
    endproperty
    a_held_burst: assert property (p_held_burst) // [RULE6]
        else $error("async burst released");

    property p_split_burst;
        @(posedge clock) disable iff (!reset_n)
        ack && op_q == OP_BURST && !async_q |-> ##1 dev_ce_n && dev_oe_n;
    endproperty
    a_split_burst: assert property (p_split_burst) // [RULE4]
        else $error("burst not split");

    property p_win_range;
        @(posedge clock) disable iff (!reset_n)
        win_q >= EXP_LO && win_q <= EXP_HI && win_q[12:0] == 13'h0000;
    endproperty
    a_win_range: assert property (p_win_range) // [RULE14]
        else $error("window base out of range");

    property p_reset_map;
        @(posedge clock) disable iff (!reset_n)
        $rose(reset_n) |-> map_q && base == TOP_BASE;
    endproperty
    a_reset_map: assert property (p_reset_map) // [RULE13]
        else $error("not mapped to top after reset");

    property p_in_window;
        @(posedge clock) disable iff (!reset_n)
        req && (op_q == OP_READ || op_q == OP_WRITE) |-> in_win;
    endproperty
    a_in_window: assert property (p_in_window) // [RULE10]
        else $error("access outside window");

    c_probe: cover property (@(posedge clock) disable iff (!reset_n)
        $rose(pres_q));
    c_boot:  cover property (@(posedge clock) disable iff (!reset_n)
        $rose(async_q));
    c_err:   cover property (@(posedge clock) disable iff (!reset_n)
        $rose(err_q));

endmodule

// [hbp_dev_model.sv]
// Behavioural flash disk device seen through its strobe pins
module hbp_dev_model import hbp_pkg::*; (
    // Device pins
    input  wire logic [DEV_ADDR_W-1:0] dev_addr,
    input  wire logic [DEV_DATA_W-1:0] dev_data_out,
    input  wire logic                  dev_data_oe_n,
    input  wire logic                  dev_ce_n,
    input  wire logic                  dev_oe_n,
    input  wire logic                  dev_we_n,
    output logic [DEV_DATA_W-1:0]      dev_data_in
);
    logic [7:0] toggle_q = PRESENCE_RST;
    logic [7:0] rd_q     = 8'h00;
    logic [7:0] wr_seen  = 8'h00;
    logic       async_q  = 1'b0;

    // Only 13 address lines reach the device, so wide windows alias
    function automatic logic [7:0] boot_byte(input logic [12:0] a);
        return a[7:0] ^ 8'hA5;
    endfunction

    // Each falling read strobe under select is one internal clock event
    always @(negedge dev_oe_n) begin
        if (!dev_ce_n && dev_addr == PRESENCE_OFS) begin
            rd_q = toggle_q;
            toggle_q = toggle_q ^ TOGGLE_MASK;
        end else begin
            rd_q = boot_byte(dev_addr);
        end
    end

    always @(negedge dev_we_n) begin
        if (!dev_ce_n && !dev_data_oe_n) begin
            wr_seen = dev_data_out;
        end
        if (!dev_ce_n && !dev_data_oe_n && dev_addr == BOOT_MODE_OFS
            && dev_data_out == ASYNC_BOOT_VAL) begin
            async_q = 1'b1;
        end
    end

    // Async boot reads follow the address; registers stay strobe-clocked
    // A released bus shows inverted data
    assign dev_data_in = (dev_ce_n || dev_oe_n) ? ~rd_q
                       : (async_q && dev_addr != PRESENCE_OFS)
                       ? boot_byte(dev_addr) : rd_q;
endmodule

// [test_boot_host_port.sv]
// Self-checking testbench for the boot host port controller
module test_boot_host_port import hbp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock   = 1'b0;
    logic        reset_n = 1'b0;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic [1:0]  htrans  = 2'h0;
    logic [31:0] haddr   = 32'h0000_0000;
    logic [31:0] hwdata  = 32'h0000_0000;
    logic [31:0] rd;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [12:0] dev_addr;
    logic [7:0]  dev_data_out;
    logic [7:0]  dev_data_in;
    logic        dev_data_oe_n;
    logic        dev_ce_n;
    logic        dev_oe_n;
    logic        dev_we_n;
    int          miscompares     = 0;
    int          samples_checked = 0;
    int          ce_falls        = 0;

    always #10 clock = ~clock;
    always @(negedge dev_ce_n) ce_falls++;

    hbp_host i_hbp_host (.clock(clock), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .dev_addr(dev_addr),
        .dev_data_out(dev_data_out), .dev_data_oe_n(dev_data_oe_n),
        .dev_data_in(dev_data_in), .dev_ce_n(dev_ce_n),
        .dev_oe_n(dev_oe_n), .dev_we_n(dev_we_n));

    hbp_dev_model i_hbp_dev_model (.dev_addr(dev_addr),
        .dev_data_out(dev_data_out), .dev_data_oe_n(dev_data_oe_n),
        .dev_ce_n(dev_ce_n), .dev_oe_n(dev_oe_n), .dev_we_n(dev_we_n),
        .dev_data_in(dev_data_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One single AHB transfer; read data lands in rd
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Issue a command and poll busy until it has risen and fallen
    task automatic cmd(input logic [2:0] c);
        bit seen;
        seen = 1'b0;
        ahb(1'b1, REG_CMD, {29'h0000_0000, c});
        repeat (100) begin
            ahb(1'b0, REG_STATUS, 32'h0000_0000);
            if (rd[0] === 1'b1) seen = 1'b1;
            else if (seen) break;
        end
    endtask

    task automatic t_reset;
        ahb(1'b0, REG_MODE, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        ahb(1'b0, REG_WINBASE, 32'h0000_0000);
        chk(rd, {12'h000, WIN_RST});
        ahb(1'b0, 8'h1C, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask

    task automatic t_probe;
        int n;
        n = ce_falls;
        cmd(OP_PROBE);
        ahb(1'b0, REG_STATUS, 32'h0000_0000);
        chk(rd & 32'h0000_0002, 32'h0000_0002);
        chk(32'(ce_falls - n), 32'h0000_0002);
        chk({24'h00_0000, i_hbp_dev_model.toggle_q}, 32'h0000_0082);
    endtask

    task automatic t_read;
        int n;
        ahb(1'b1, REG_SYSADDR, {12'h000, TOP_BASE} + 32'h0000_0010);
        cmd(OP_READ);
        ahb(1'b0, REG_RDATA, 32'h0000_0000);
        chk(rd & 32'h0000_00FF, 32'h0000_00B5);
        n = ce_falls;
        ahb(1'b1, REG_SYSADDR, 32'h0001_2345);
        cmd(OP_READ);
        ahb(1'b0, REG_STATUS, 32'h0000_0000);
        chk(rd & 32'h0000_0004, 32'h0000_0004);
        chk(32'(ce_falls - n), 32'h0000_0000);
        ahb(1'b1, REG_STATUS, 32'h0000_0004);
        chk({24'h00_0000, i_hbp_dev_model.toggle_q}, 32'h0000_0082);
    endtask

    task automatic t_burst(input int selects);
        int n;
        ahb(1'b1, REG_SYSADDR, {12'h000, TOP_BASE} + 32'h0000_0020);
        n = ce_falls;
        cmd(OP_BURST);
        ahb(1'b0, REG_RDATA, 32'h0000_0000);
        chk(rd, 32'h8687_8485);
        chk(32'(ce_falls - n), 32'(selects));
    endtask

    task automatic t_boot;
        cmd(OP_BOOT);
        chk({31'h0, i_hbp_dev_model.async_q}, 32'h0000_0001);
        ahb(1'b0, REG_MODE, 32'h0000_0000);
        chk(rd & 32'h0000_0002, 32'h0000_0002);
    endtask

    task automatic t_remap;
        int n;
        ahb(1'b1, REG_WINBASE, 32'h000F_0000);
        ahb(1'b0, REG_WINBASE, 32'h0000_0000);
        chk(rd, {12'h000, WIN_RST});
        ahb(1'b1, REG_WINBASE, {12'h000, EXP_LO});
        ahb(1'b1, REG_MODE, 32'h0000_0000);
        ahb(1'b1, REG_SYSADDR, {12'h000, EXP_LO} + 32'h0000_0030);
        cmd(OP_READ);
        ahb(1'b0, REG_RDATA, 32'h0000_0000);
        chk(rd & 32'h0000_00FF, 32'h0000_0095);
        ahb(1'b1, REG_WDATA, 32'h0000_005A);
        n = ce_falls;
        cmd(OP_WRITE);
        chk({24'h00_0000, i_hbp_dev_model.wr_seen}, 32'h0000_005A);
        chk(32'(ce_falls - n), 32'h0000_0001);
        ahb(1'b0, REG_WDATA, 32'h0000_0000);
        chk(rd, 32'h0000_005A);
        ahb(1'b0, REG_STATUS, 32'h0000_0000);
        chk(rd & 32'h0000_0004, 32'h0000_0000);
    endtask

    initial begin
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        t_reset();
        t_probe();
        t_read();
        t_burst(4);
        t_boot();
        t_burst(1);
        t_probe();
        t_remap();
        tally_and_finish();
    end

    initial begin
        repeat (50000) @(posedge clock);
        miscompares++;
        tally_and_finish();
    end
endmodule
